// >>> rtl/ppm_pkg.sv
package ppm_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned SW_RST_NS      = 80;
  localparam int unsigned SW_RST_CYC     = (SW_RST_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RELEASE_NS     = 640;
  localparam int unsigned RELEASE_CYC    = (RELEASE_NS * CLK_MHZ) / 1000;
  localparam int unsigned CNT_W          = 8;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W         = 5;
  localparam int unsigned DATA_W         = 16;
  localparam logic [4:0]  REG_CTRL       = 5'h00;
  localparam logic [4:0]  REG_STAT       = 5'h01;
  localparam logic [4:0]  REG_ADV        = 5'h04;
  localparam logic [4:0]  REG_LPA        = 5'h05;
  localparam logic [4:0]  REG_ERRCNT     = 5'h12;
  localparam logic [4:0]  REG_EXT2       = 5'h13;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_SW_RST    = 15;
  localparam int unsigned CTRL_SPEED     = 13;
  localparam int unsigned CTRL_AN_EN     = 12;
  localparam int unsigned CTRL_PDOWN     = 11;
  localparam int unsigned CTRL_DUPLEX    = 8;
  localparam int unsigned STAT_ABL_LSB   = 11;
  localparam int unsigned STAT_AN_DONE   = 5;
  localparam int unsigned STAT_RFAULT    = 4;
  localparam int unsigned STAT_LINK      = 2;
  localparam int unsigned STAT_JABBER    = 1;
  localparam int unsigned ADV_ABL_LSB    = 5;
  localparam int unsigned EXT2_SAVE100   = 0;
  localparam int unsigned EXT2_SAVE10    = 1;
  localparam int unsigned ABL_10HD       = 0;
  localparam int unsigned ABL_10FD       = 1;
  localparam int unsigned ABL_100HD      = 2;
  localparam int unsigned ABL_100FD      = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CTRL_RST       = 16'h3100;
  localparam logic [3:0]  ADV_RST        = 4'hF;
  localparam logic [1:0]  EXT2_RST       = 2'h0;
  localparam logic [3:0]  LOCAL_ABL      = 4'hF;
  localparam logic [7:0]  ERRCNT_MAX     = 8'hFF;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic speed_100;
    logic full_duplex;
  } ppm_mode_t;

  typedef struct packed {
    logic nibble_serdes;
    logic code_4b5b;
    logic nrzi;
    logic mlt3;
    logic scramble;
    logic manchester;
    logic loopback;
    logic sqe_test;
  } ppm_path_t;

  typedef enum logic [2:0] {
    ST_RESET,
    ST_SWRST,
    ST_PDOWN,
    ST_RELEASE,
    ST_RUN
  } ppm_state_t;

endpackage

// >>> rtl/ppm_an_resolve.sv
`timescale 1ns/1ps
module ppm_an_resolve (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  // request
  input  wire logic              clear_in,
  input  wire logic              valid_in,
  input  wire logic [3:0]        local_abl_in,
  input  wire logic [3:0]        partner_abl_in,
  // result
  output ppm_pkg::ppm_mode_t     mode_out,
  output logic                   done_out
);

  ppm_pkg::ppm_mode_t mode_q;
  logic               done_q;
  logic [3:0]         common;

  assign common = local_abl_in & partner_abl_in;

  // highest common mode wins: 100 full, 100 half, 10 full, 10 half
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_q <= '0;
      done_q <= 1'b0;
    end else if (clear_in) begin
      done_q <= 1'b0;
    end else if (valid_in && !done_q && (common != 4'h0)) begin
      done_q <= 1'b1;
      if (common[ppm_pkg::ABL_100FD]) begin
        mode_q <= '{speed_100: 1'b1, full_duplex: 1'b1};
      end else if (common[ppm_pkg::ABL_100HD]) begin
        mode_q <= '{speed_100: 1'b1, full_duplex: 1'b0};
      end else if (common[ppm_pkg::ABL_10FD]) begin
        mode_q <= '{speed_100: 1'b0, full_duplex: 1'b1};
      end else begin
        mode_q <= '{speed_100: 1'b0, full_duplex: 1'b0};
      end
    end
  end

  assign mode_out = mode_q;
  assign done_out = done_q;

endmodule

// >>> rtl/ppm_phy_ctrl.sv
// Behaviour
// - power down on reset pin or bit
// - powered down: MAC outputs zero, management alive (bit power down only; reset pin holds the register port in reset)
// - powered down: line transmit pins released
// - bit power down keeps registers, clears latches
// - reset power down restores all defaults
// - optional 100M modules off at 10M
// - optional 10M modules off at 100M
// - negotiation runs only while enabled
// - negotiation picks highest common mode
// - 100M path: serdes, 4B5B, NRZI, MLT3, scramble
// - 10M path: serdes and Manchester coding
// - full duplex: both paths at once
// - 10M full duplex: no loopback, no SQE
// - full duplex: carrier on receive, no collision
// - half duplex: carrier either way, collision
// - software reset does not power down
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps
module ppm_phy_ctrl (
  // clock and hardware reset pin
  input  wire logic                        clk_in,
  input  wire logic                        rst_n_in,
  // register port
  input  wire logic [ppm_pkg::ADDR_W-1:0]  reg_addr_in,
  input  wire logic [ppm_pkg::DATA_W-1:0]  reg_wdata_in,
  input  wire logic                        reg_wr_in,
  input  wire logic                        reg_rd_in,
  output logic      [ppm_pkg::DATA_W-1:0]  reg_rdata_out,
  // MAC side
  input  wire logic                        tx_en_in,
  input  wire logic [3:0]                  txd_in,
  output logic                             rx_dv_out,
  output logic      [3:0]                  rxd_out,
  output logic                             crs_out,
  output logic                             col_out,
  // line side
  input  wire logic                        rx_active_in,
  input  wire logic [3:0]                  rx_nibble_in,
  input  wire logic                        rx_error_in,
  input  wire logic                        link_up_in,
  input  wire logic                        jabber_in,
  input  wire logic                        remote_fault_in,
  input  wire logic                        line_sym_pos_in,
  input  wire logic                        line_sym_neg_in,
  output logic                             line_tx_pos_out,
  output logic                             line_tx_neg_out,
  output logic                             line_tx_oe_out,
  // negotiation partner
  input  wire logic [3:0]                  partner_abl_in,
  input  wire logic                        partner_valid_in,
  // internal control
  output logic                             power_down_out,
  output logic                             an_run_out,
  output logic                             mod100_en_out,
  output logic                             mod10_en_out,
  output ppm_pkg::ppm_mode_t               mode_out,
  output ppm_pkg::ppm_path_t               path_out
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // registers and sequencer state
  // ----------------------------------------------------------------
  ppm_pkg::ppm_state_t             state_q;
  logic [ppm_pkg::CNT_W-1:0]       cnt_q;
  logic [15:0]                     ctrl_q;
  logic [3:0]                      adv_q;
  logic [1:0]                      ext2_q;
  logic                            link_ll_q;
  logic                            jabber_lh_q;
  logic                            rfault_lh_q;
  logic [7:0]                      errcnt_q;
  logic [ppm_pkg::DATA_W-1:0]      rdata_q;
  ppm_pkg::ppm_mode_t              an_mode;
  logic                            an_done;
  logic                            sw_rst;
  logic                            pd_bit;
  logic                            live;
  logic                            stat_rd;
  logic                            err_rd;
  logic                            wr_ctrl;

  function automatic logic hit(input logic [ppm_pkg::ADDR_W-1:0] a, input logic [4:0] r);
    hit = (a == r);
  endfunction

  assign sw_rst  = (state_q == ppm_pkg::ST_SWRST);
  assign pd_bit  = ctrl_q[ppm_pkg::CTRL_PDOWN];
  assign live    = (state_q == ppm_pkg::ST_RUN);
  assign wr_ctrl = reg_wr_in && hit(reg_addr_in, ppm_pkg::REG_CTRL);
  assign stat_rd = reg_rd_in && hit(reg_addr_in, ppm_pkg::REG_STAT);
  assign err_rd  = reg_rd_in && hit(reg_addr_in, ppm_pkg::REG_ERRCNT);

  // ----------------------------------------------------------------
  // reset, power-down and release sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q <= ppm_pkg::ST_RESET;
      cnt_q   <= '0;
    end else begin
      case (state_q)
        ppm_pkg::ST_RESET: begin
          state_q <= ppm_pkg::ST_RELEASE;
          cnt_q   <= '0;
        end
        ppm_pkg::ST_SWRST: begin
          // software reset holds the block but never powers it down
          if (cnt_q == ppm_pkg::CNT_W'(ppm_pkg::SW_RST_CYC - 1)) begin
            state_q <= ppm_pkg::ST_RELEASE;
            cnt_q   <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ppm_pkg::ST_PDOWN: begin
          if (!pd_bit) begin
            state_q <= ppm_pkg::ST_RELEASE;
            cnt_q   <= '0;
          end
        end
        ppm_pkg::ST_RELEASE: begin
          if (pd_bit) begin
            state_q <= ppm_pkg::ST_PDOWN;
          end else if (cnt_q == ppm_pkg::CNT_W'(ppm_pkg::RELEASE_CYC - 1)) begin
            state_q <= ppm_pkg::ST_RUN;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ppm_pkg::ST_RUN: begin
          if (wr_ctrl && reg_wdata_in[ppm_pkg::CTRL_SW_RST]) begin
            state_q <= ppm_pkg::ST_SWRST;
            cnt_q   <= '0;
          end else if (pd_bit) begin
            state_q <= ppm_pkg::ST_PDOWN;
          end
        end
        default: begin
          state_q <= ppm_pkg::ST_RESET;
          cnt_q   <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ctrl_q <= ppm_pkg::CTRL_RST;
      adv_q  <= ppm_pkg::ADV_RST;
      ext2_q <= ppm_pkg::EXT2_RST;
    end else if (sw_rst) begin
      // defaults again; the reset bit reads one until the hold ends
      ctrl_q                      <= ppm_pkg::CTRL_RST;
      ctrl_q[ppm_pkg::CTRL_SW_RST] <= (cnt_q != ppm_pkg::CNT_W'(ppm_pkg::SW_RST_CYC - 1));
      adv_q                       <= ppm_pkg::ADV_RST;
      ext2_q                      <= ppm_pkg::EXT2_RST;
    end else if (reg_wr_in) begin
      // power-down entry leaves these untouched
      if (hit(reg_addr_in, ppm_pkg::REG_CTRL)) begin
        ctrl_q <= reg_wdata_in;
      end
      if (hit(reg_addr_in, ppm_pkg::REG_ADV)) begin
        adv_q <= reg_wdata_in[ppm_pkg::ADV_ABL_LSB +: 4];
      end
      if (hit(reg_addr_in, ppm_pkg::REG_EXT2)) begin
        ext2_q <= reg_wdata_in[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // latching status bits
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      link_ll_q   <= 1'b0;
      jabber_lh_q <= 1'b0;
      rfault_lh_q <= 1'b0;
    end else if (!live) begin
      link_ll_q   <= 1'b0;
      jabber_lh_q <= 1'b0;
      rfault_lh_q <= 1'b0;
    end else begin
      // a read re-arms the latch; an event in the same cycle wins
      link_ll_q   <= link_up_in & (link_ll_q | stat_rd);
      jabber_lh_q <= jabber_in | (jabber_lh_q & ~stat_rd);
      rfault_lh_q <= remote_fault_in | (rfault_lh_q & ~stat_rd);
    end
  end

  // saturating error count, cleared by its read
  always_ff @(posedge clk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      errcnt_q <= '0;
    end else if (!live) begin
      errcnt_q <= '0;
    end else if (rx_error_in) begin
      if (err_rd) begin
        errcnt_q <= 8'h01;
      end else if (errcnt_q != ppm_pkg::ERRCNT_MAX) begin
        errcnt_q <= errcnt_q + 1'b1;
      end
    end else if (err_rd) begin
      errcnt_q <= '0;
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rdata_q <= '0;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        ppm_pkg::REG_CTRL:   rdata_q <= ctrl_q;
        ppm_pkg::REG_STAT:   rdata_q <= {1'b0, ppm_pkg::LOCAL_ABL, 5'h00, an_done, rfault_lh_q,
                                         1'b0, link_ll_q, jabber_lh_q, 1'b1};
        ppm_pkg::REG_ADV:    rdata_q <= {7'h00, adv_q, 5'h01};
        ppm_pkg::REG_LPA:    rdata_q <= {7'h00, partner_abl_in, 5'h01};
        ppm_pkg::REG_ERRCNT: rdata_q <= {8'h00, errcnt_q};
        ppm_pkg::REG_EXT2:   rdata_q <= {14'h0000, ext2_q};
        default:             rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata_out = rdata_q;

  // ----------------------------------------------------------------
  // negotiation and operating mode
  // ----------------------------------------------------------------
  logic an_run;

  assign an_run = live && ctrl_q[ppm_pkg::CTRL_AN_EN] && !pd_bit;

  ppm_an_resolve u_resolve (
    .clk_in         (clk_in),
    .rst_n_in       (rst_sync_q),
    .clear_in       (!an_run),
    .valid_in       (partner_valid_in),
    .local_abl_in   (adv_q & ppm_pkg::LOCAL_ABL),
    .partner_abl_in (partner_abl_in),
    .mode_out       (an_mode),
    .done_out       (an_done)
  );

  ppm_pkg::ppm_mode_t mode_q;
  ppm_pkg::ppm_path_t path_q;
  logic               mod100_q;
  logic               mod10_q;

  always_ff @(posedge clk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      mode_q <= '0;
    end else if (an_run) begin
      mode_q <= an_mode;
    end else begin
      mode_q <= '{speed_100: ctrl_q[ppm_pkg::CTRL_SPEED], full_duplex: ctrl_q[ppm_pkg::CTRL_DUPLEX]};
    end
  end

  // module enables and coding selection
  always_ff @(posedge clk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      mod100_q <= 1'b0;
      mod10_q  <= 1'b0;
      path_q   <= '0;
    end else if (!live) begin
      mod100_q <= 1'b0;
      mod10_q  <= 1'b0;
      path_q   <= '0;
    end else begin
      mod100_q <= mode_q.speed_100 | ~ext2_q[ppm_pkg::EXT2_SAVE100];
      mod10_q  <= ~mode_q.speed_100 | ~ext2_q[ppm_pkg::EXT2_SAVE10];
      path_q.nibble_serdes <= 1'b1;
      path_q.code_4b5b     <= mode_q.speed_100;
      path_q.nrzi          <= mode_q.speed_100;
      path_q.mlt3          <= mode_q.speed_100;
      path_q.scramble      <= mode_q.speed_100;
      path_q.manchester    <= ~mode_q.speed_100;
      path_q.loopback      <= ~mode_q.speed_100 & ~mode_q.full_duplex;
      path_q.sqe_test      <= ~mode_q.speed_100 & ~mode_q.full_duplex;
    end
  end

  // ----------------------------------------------------------------
  // MAC outputs and line transmit
  // ----------------------------------------------------------------
  logic       crs_q;
  logic       col_q;
  logic       rx_dv_q;
  logic [3:0] rxd_q;
  logic       tx_pos_q;
  logic       tx_neg_q;
  logic       loop_now;

  // half-duplex 10M echoes transmit data when the line is quiet
  assign loop_now = path_q.loopback && tx_en_in && !rx_active_in;

  always_ff @(posedge clk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      crs_q   <= 1'b0;
      col_q   <= 1'b0;
      rx_dv_q <= 1'b0;
      rxd_q   <= '0;
    end else if (!live) begin
      crs_q   <= 1'b0;
      col_q   <= 1'b0;
      rx_dv_q <= 1'b0;
      rxd_q   <= '0;
    end else if (mode_q.full_duplex) begin
      crs_q   <= rx_active_in;
      col_q   <= 1'b0;
      rx_dv_q <= rx_active_in;
      rxd_q   <= rx_nibble_in;
    end else begin
      crs_q   <= rx_active_in | tx_en_in;
      col_q   <= rx_active_in & tx_en_in;
      rx_dv_q <= rx_active_in | loop_now;
      rxd_q   <= loop_now ? txd_in : rx_nibble_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      tx_pos_q <= 1'b0;
      tx_neg_q <= 1'b0;
    end else begin
      tx_pos_q <= live & line_sym_pos_in;
      tx_neg_q <= live & line_sym_neg_in;
    end
  end

  assign crs_out         = crs_q;
  assign col_out         = col_q;
  assign rx_dv_out       = rx_dv_q;
  assign rxd_out         = rxd_q;
  assign line_tx_pos_out = tx_pos_q;
  assign line_tx_neg_out = tx_neg_q;
  assign line_tx_oe_out  = (state_q != ppm_pkg::ST_PDOWN) && (state_q != ppm_pkg::ST_RESET)
                           && !pd_bit;
  assign power_down_out  = !rst_sync_q || (state_q == ppm_pkg::ST_RESET) || pd_bit;
  assign an_run_out      = an_run;
  assign mod100_en_out   = mod100_q;
  assign mod10_en_out    = mod10_q;
  assign mode_out        = mode_q;
  assign path_out        = path_q;

endmodule

// >>> verif/ppm_phy_ctrl_chk.sv
`timescale 1ns/1ps
module ppm_phy_ctrl_chk (
  // clock and reset
  input wire logic                       clk_in,
  input wire logic                       rst_n_in,
  // register port
  input wire logic [ppm_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic                       reg_rd_in,
  input wire logic [ppm_pkg::DATA_W-1:0] reg_rdata_out,
  // MAC and line side
  input wire logic                       tx_en_in,
  input wire logic                       rx_active_in,
  input wire logic                       rx_dv_out,
  input wire logic                       crs_out,
  input wire logic                       col_out,
  input wire logic                       line_tx_oe_out,
  // control
  input wire logic                       power_down_out,
  input wire logic                       an_run_out,
  input wire ppm_pkg::ppm_mode_t         mode_out
);
  default clocking dc @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // ------------------------------------------------------------
  // steady states, three samples long so output lags settle
  // ------------------------------------------------------------
  sequence s_down; power_down_out [*3]; endsequence
  sequence s_full; (mode_out.full_duplex && !power_down_out) [*3]; endsequence
  sequence s_half; (!mode_out.full_duplex && !power_down_out) [*3]; endsequence

  a_rst_pdown: assert property ($rose(rst_n_in) |-> power_down_out [*2])
    else $error("power down dropped while reset is synchronised");
  a_oe_off: assert property (power_down_out |-> !line_tx_oe_out)
    else $error("line pins driven in power down");
  a_mac_quiet: assert property (s_down |-> !(crs_out || col_out || rx_dv_out))
    else $error("MAC output active in power down");
  // power down with the reset pin high three cycles back reads the bit as one
  a_mgmt_alive: assert property (s_down ##0 (reg_rd_in && reg_addr_in == ppm_pkg::REG_CTRL)
    ##0 $past(rst_n_in, 3) |=> reg_rdata_out[ppm_pkg::CTRL_PDOWN])
    else $error("control read lost in power down");
  a_full_col: assert property (s_full |-> !col_out)
    else $error("collision in full duplex");
  a_full_crs: assert property (s_full ##0 crs_out |-> $past(rx_active_in))
    else $error("carrier without receive in full duplex");
  a_no_loop: assert property (s_full ##0 rx_dv_out |-> $past(rx_active_in))
    else $error("receive valid without receive in full duplex");
  a_half_col: assert property (s_half ##0 col_out |-> $past(rx_active_in && tx_en_in))
    else $error("collision without both directions");
  a_half_crs: assert property (s_half ##0 crs_out |-> $past(rx_active_in || tx_en_in))
    else $error("carrier without activity in half duplex");
  a_an_gate: assert property (an_run_out |-> !power_down_out)
    else $error("negotiation running in power down");
endmodule

bind ppm_phy_ctrl ppm_phy_ctrl_chk u_chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .tx_en_in(tx_en_in), .rx_active_in(rx_active_in),
  .rx_dv_out(rx_dv_out), .crs_out(crs_out), .col_out(col_out), .line_tx_oe_out(line_tx_oe_out),
  .power_down_out(power_down_out), .an_run_out(an_run_out), .mode_out(mode_out)
);

// >>> verif/ppm_mac_model.sv
`timescale 1ns/1ps
module ppm_mac_model (
  // clock
  input  wire logic       clk_in,
  // scenario control
  input  wire logic       tx_req_in,
  input  wire logic       rx_req_in,
  // toward the block
  output logic            tx_en_out,
  output logic [3:0]      txd_out,
  output logic            rx_active_out,
  output logic [3:0]      rx_nibble_out
);
  logic [3:0] cnt_q = 4'h0;
  logic       tx_q  = 1'b0;
  logic       rx_q  = 1'b0;

  always @(posedge clk_in) begin
    cnt_q <= cnt_q + 4'h1;
    tx_q  <= tx_req_in;
    rx_q  <= rx_req_in;
  end

  // idle nibbles keep changing so stale data never looks valid
  assign tx_en_out     = tx_q;
  assign txd_out       = tx_q ? cnt_q : ~cnt_q;
  assign rx_active_out = rx_q;
  assign rx_nibble_out = rx_q ? ~cnt_q : cnt_q;
endmodule

// >>> verif/ppm_phy_ctrl_tb.sv
`timescale 1ns/1ps
module ppm_phy_ctrl_tb;
  logic               clk_in;
  logic               rst_n_in;
  logic [4:0]         reg_addr;
  logic [15:0]        reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic [15:0]        rdata;
  logic [15:0]        d;
  logic               tx_req, rx_req, tx_en, rx_act, rx_err, jabber, sym_pos, p_valid;
  logic [3:0]         txd, rx_nib, p_abl, rxd;
  logic               rx_dv, crs, col, tx_pos, tx_neg, oe, pdown, an_run, m100, m10;
  ppm_pkg::ppm_mode_t mode;
  ppm_pkg::ppm_path_t path;
  int                 num_errors = 0;
  int                 n_tests = 0;

  ppm_mac_model mac (.clk_in(clk_in), .tx_req_in(tx_req), .rx_req_in(rx_req), .tx_en_out(tx_en),
    .txd_out(txd), .rx_active_out(rx_act), .rx_nibble_out(rx_nib));

  ppm_phy_ctrl dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
    .tx_en_in(tx_en), .txd_in(txd), .rx_dv_out(rx_dv), .rxd_out(rxd), .crs_out(crs), .col_out(col),
    .rx_active_in(rx_act), .rx_nibble_in(rx_nib), .rx_error_in(rx_err), .link_up_in(1'b1),
    .jabber_in(jabber), .remote_fault_in(1'b0), .line_sym_pos_in(sym_pos), .line_sym_neg_in(sym_pos),
    .line_tx_pos_out(tx_pos), .line_tx_neg_out(tx_neg), .line_tx_oe_out(oe), .partner_abl_in(p_abl),
    .partner_valid_in(p_valid), .power_down_out(pdown), .an_run_out(an_run), .mod100_en_out(m100),
    .mod10_en_out(m10), .mode_out(mode), .path_out(path));

  // ------------------------------------------------------------
  // bus and check tasks
  // ------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk_in);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk_in);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(posedge clk_in);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_in);
    reg_rd   <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic rdc(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] v;
    rd(a, v);
    chk(v, e);
  endtask

  task automatic errs();
    repeat (3) begin
      rx_err <= 1'b1;
      cyc(1);
      rx_err <= 1'b0;
      cyc(1);
    end
  endtask

  task automatic hw_reset();
    rst_n_in <= 1'b0;
    cyc(2);
    #1;
    chk({pdown, oe}, 2'b10);
    cyc(8);
    rst_n_in <= 1'b1;
    cyc(ppm_pkg::RELEASE_CYC + 6);
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // clock, watchdog and tests
  // ------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  initial begin
    #100000;
    num_errors++;
    test_done();
  end

  initial begin
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    tx_req = 1'b0;
    rx_req = 1'b0;
    rx_err = 1'b0;
    jabber = 1'b0;
    sym_pos = 1'b0;
    p_abl = 4'h0;
    p_valid = 1'b0;
    hw_reset();
    p_abl <= 4'h6;
    p_valid <= 1'b1;
    cyc(8);
    #1;
    chk(an_run, 1'b1);
    chk(mode, 2'b10);
    wr(ppm_pkg::REG_CTRL, 16'h0100);
    cyc(4);
    #1;
    chk(an_run, 1'b0);
    chk(mode, 2'b01);
    $display("test negotiation done");
    for (int i = 0; i < 4; i++) begin
      wr(ppm_pkg::REG_CTRL, {2'b00, i[1], 4'h0, !i[0], 8'h00});
      tx_req <= 1'b1;
      rx_req <= 1'b0;
      cyc(6);
      #1;
      chk(crs, i[0]);
      chk(col, 1'b0);
      chk(rx_dv, i == 1);
      cyc(1);
      rx_req <= 1'b1;
      cyc(4);
      #1;
      chk(crs, 1'b1);
      chk(col, i[0]);
      chk(path[7:2], i[1] ? 6'h3E : 6'h21);
      chk(path[1:0], (i == 1) ? 2'h3 : 2'h0);
    end
    $display("test duplex done");
    for (int i = 0; i < 4; i++) begin
      wr(ppm_pkg::REG_CTRL, {2'b00, i[1], 13'h0100});
      wr(ppm_pkg::REG_EXT2, {14'h0000, i[0], i[0]});
      cyc(5);
      #1;
      chk(m100, !(i[0] && !i[1]));
      chk(m10, !(i[0] && i[1]));
    end
    $display("test power saving done");
    cyc(1);
    errs();
    rdc(ppm_pkg::REG_ERRCNT, 16'h0003);
    errs();
    jabber <= 1'b1;
    sym_pos <= 1'b1;
    cyc(1);
    jabber <= 1'b0;
    wr(ppm_pkg::REG_CTRL, 16'h2900);
    cyc(4);
    #1;
    chk({pdown, oe}, 2'b10);
    chk({crs, col, rx_dv, rxd, tx_pos, tx_neg}, 9'h000);
    rdc(ppm_pkg::REG_CTRL, 16'h2900);
    rdc(ppm_pkg::REG_EXT2, 16'h0003);
    wr(ppm_pkg::REG_CTRL, 16'h2100);
    cyc(ppm_pkg::RELEASE_CYC + 6);
    #1;
    chk({pdown, oe, crs, tx_pos, tx_neg}, 5'h0F);
    rdc(ppm_pkg::REG_ERRCNT, 16'h0000);
    rd(ppm_pkg::REG_STAT, d);
    chk(d[ppm_pkg::STAT_JABBER], 1'b0);
    $display("test power down done");
    wr(ppm_pkg::REG_CTRL, 16'hA100);
    repeat (20) begin
      cyc(1);
      #1;
      chk(pdown, 1'b0);
    end
    cyc(ppm_pkg::RELEASE_CYC);
    rdc(ppm_pkg::REG_CTRL, ppm_pkg::CTRL_RST);
    $display("test software reset done");
    wr(ppm_pkg::REG_EXT2, 16'h0001);
    wr(ppm_pkg::REG_CTRL, 16'h0100);
    hw_reset();
    rdc(ppm_pkg::REG_CTRL, ppm_pkg::CTRL_RST);
    rdc(ppm_pkg::REG_EXT2, 16'h0000);
    rdc(5'h1F, 16'h0000);
    $display("test hardware reset done");
    test_done();
  end
endmodule
